//--- core/ewps_top.sv
`include "ewps_consts.svh"

module ewps_top
  import ewps_pkg::*;
#(
  parameter int unsigned TWC_CYCLES = `EWPS_TWC_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic nv_init_i,
  input wire logic line_rise_i,
  input wire logic standby_i,
  input wire logic header_fall_i,
  input wire logic cmd_valid_i,
  input wire logic [7:0] cmd_byte_i,
  input wire logic data_valid_i,
  input wire logic [7:0] data_byte_i,
  input wire logic ack_valid_i,
  input wire logic ack_mak_i,
  input wire logic page_write_i,
  input wire logic [7:0] page_addr_i,
  output logic slave_ack_o,
  output logic cmd_reject_o,
  output logic tx_valid_o,
  output logic [7:0] tx_byte_o,
  output logic wr_start_o,
  output logic [1:0] wr_kind_o,
  output logic [7:0] wr_addr_o,
  output logic [7:0] wr_data_o,
  output logic array_ready_o,
  output logic busy_o,
  output logic latch_o,
  output logic [1:0] protect_o,
  output logic [1:0] power_o
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  ewps_state_e state_reg;
  ewps_state_e state_next;
  logic latch_reg;
  logic slave_ack_reg;
  logic reject_reg;
  logic tx_valid_reg;
  logic [7:0] tx_byte_reg;
  logic [7:0] cmd_reg;
  logic [1:0] bp_data_reg;
  logic wr_start_reg;
  ewps_kind_e wr_kind_reg;
  logic [7:0] wr_addr_reg;
  logic [7:0] wr_data_reg;
  logic [1:0] power_reg;
  logic busy;
  logic [1:0] bp;
  logic [1:0] bp_shown;
  logic [7:0] status_byte;
  logic is_nack;
  logic is_mak;
  logic other_resp;
  logic one_byte_cmd;
  logic exec_one;
  logic exec_ws;
  logic go_bulk;
  logic go_status;
  logic go_page;
  logic start_any;
  logic send_status;
  logic page_prot;
  logic [3:0] blk_prot;
  ewps_kind_e start_kind;

  // ----------------------------------------------------------------
  // Nonvolatile cell and write timer
  // ----------------------------------------------------------------
  ewps_nvcell #(
    .TWC_CYCLES(TWC_CYCLES)
  ) u_nvcell (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .nv_init_i(nv_init_i),
    .start_i(start_any),
    .kind_i(start_kind),
    .bp_new_i(bp_data_reg),
    .busy_o(busy),
    .bp_o(bp),
    .bp_shown_o(bp_shown)
  );

  // ----------------------------------------------------------------
  // Response decode
  // ----------------------------------------------------------------
  assign is_nack = ack_valid_i && !ack_mak_i;
  assign is_mak = ack_valid_i && ack_mak_i;
  assign other_resp = is_mak || standby_i;

  always_comb begin
    one_byte_cmd = 1'b0;
    case (cmd_byte_i)
      `EWPS_CMD_ARM: one_byte_cmd = 1'b1;
      `EWPS_CMD_DISARM: one_byte_cmd = 1'b1;
      `EWPS_CMD_CLEAR: one_byte_cmd = 1'b1;
      `EWPS_CMD_FILL: one_byte_cmd = 1'b1;
      default: one_byte_cmd = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Block protection per quarter of the array
  // ----------------------------------------------------------------
  // Quarter q covers addresses whose top two bits equal q.
  genvar q;
  generate
    for (q = 0; q < 4; q = q + 1) begin : g_blk
      always_comb begin
        case (bp)
          `EWPS_BP_NONE: blk_prot[q] = 1'b0;
          `EWPS_BP_QUARTER: blk_prot[q] =
            (8'(q * 64) >= `EWPS_QUARTER_BASE);
          `EWPS_BP_HALF: blk_prot[q] =
            (8'(q * 64) >= `EWPS_HALF_BASE);
          `EWPS_BP_ALL: blk_prot[q] = 1'b1;
          default: blk_prot[q] = 1'b1;
        endcase
      end
    end
  endgenerate

  assign page_prot = blk_prot[page_addr_i[7:6]];

  // ----------------------------------------------------------------
  // Command execution and write start
  // ----------------------------------------------------------------
  assign exec_one = (state_reg == EWPS_ONE_END) && is_nack;
  assign exec_ws = (state_reg == EWPS_WS_END) && is_nack;

  assign go_bulk = exec_one && latch_reg && !busy &&
                   (bp == `EWPS_BP_NONE) &&
                   (cmd_reg == `EWPS_CMD_CLEAR ||
                    cmd_reg == `EWPS_CMD_FILL);
  assign go_status = exec_ws && latch_reg && !busy;
  assign go_page = page_write_i && latch_reg && !busy &&
                   !page_prot;
  assign start_any = go_bulk || go_status || go_page;

  always_comb begin
    if (go_status) begin
      start_kind = EWPS_WK_STATUS;
    end else if (go_bulk && cmd_reg == `EWPS_CMD_FILL) begin
      start_kind = EWPS_WK_FILL;
    end else if (go_bulk) begin
      start_kind = EWPS_WK_CLEAR;
    end else begin
      start_kind = EWPS_WK_PAGE;
    end
  end

  // ----------------------------------------------------------------
  // Write-enable latch
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      latch_reg <= 1'b0;
    end else if (exec_one && cmd_reg == `EWPS_CMD_ARM) begin
      latch_reg <= 1'b1;
    end else if (exec_one && cmd_reg == `EWPS_CMD_DISARM) begin
      latch_reg <= 1'b0;
    end else if (start_any) begin
      latch_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Sequence state machine
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      EWPS_SHUT: begin
        if (line_rise_i) begin
          state_next = EWPS_IDLE;
        end
      end
      EWPS_IDLE: begin
        if (standby_i) begin
          state_next = EWPS_STBY;
        end
      end
      EWPS_STBY: begin
        if (header_fall_i) begin
          state_next = EWPS_HDR;
        end
      end
      EWPS_HDR: begin
        if (standby_i) begin
          state_next = EWPS_STBY;
        end else if (cmd_valid_i) begin
          if (one_byte_cmd) begin
            state_next = EWPS_ONE_END;
          end else if (cmd_byte_i == `EWPS_CMD_STAT_RD) begin
            state_next = EWPS_RD_CMD;
          end else if (cmd_byte_i == `EWPS_CMD_STAT_WR) begin
            state_next = EWPS_WS_CMD;
          end else begin
            state_next = EWPS_IDLE;
          end
        end
      end
      EWPS_ONE_END: begin
        if (is_nack || other_resp) begin
          state_next = EWPS_IDLE;
        end
      end
      EWPS_RD_CMD: begin
        if (is_mak) begin
          state_next = EWPS_RD_BYTE;
        end else if (is_nack || standby_i) begin
          state_next = EWPS_IDLE;
        end
      end
      EWPS_RD_BYTE: begin
        if (is_nack || standby_i) begin
          state_next = EWPS_IDLE;
        end
      end
      EWPS_WS_CMD: begin
        if (is_mak) begin
          state_next = EWPS_WS_DATA;
        end else if (is_nack || standby_i) begin
          state_next = EWPS_IDLE;
        end
      end
      EWPS_WS_DATA: begin
        if (standby_i) begin
          state_next = EWPS_IDLE;
        end else if (data_valid_i) begin
          state_next = EWPS_WS_END;
        end
      end
      EWPS_WS_END: begin
        if (is_nack || other_resp) begin
          state_next = EWPS_IDLE;
        end
      end
      default: state_next = EWPS_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= EWPS_SHUT;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // Captured command and status-write data
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd_reg <= 8'h00;
    end else if (state_reg == EWPS_HDR && cmd_valid_i) begin
      cmd_reg <= cmd_byte_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bp_data_reg <= `EWPS_BP_NONE;
    end else if (state_reg == EWPS_WS_DATA && data_valid_i) begin
      bp_data_reg <= {data_byte_i[`EWPS_ST_BP_HI],
                      data_byte_i[`EWPS_ST_BP_LO]};
    end
  end

  // ----------------------------------------------------------------
  // Acknowledge and reject answers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      slave_ack_reg <= 1'b0;
    end else begin
      case (state_reg)
        EWPS_ONE_END: slave_ack_reg <= is_nack;
        EWPS_RD_CMD: slave_ack_reg <= ack_valid_i;
        EWPS_RD_BYTE: slave_ack_reg <= ack_valid_i;
        EWPS_WS_CMD: slave_ack_reg <= is_mak;
        EWPS_WS_END: slave_ack_reg <= is_nack;
        default: slave_ack_reg <= 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reject_reg <= 1'b0;
    end else begin
      reject_reg <= ((state_reg == EWPS_ONE_END ||
                      state_reg == EWPS_WS_END) &&
                     other_resp) ||
                    (state_reg == EWPS_WS_CMD && is_nack);
    end
  end

  // ----------------------------------------------------------------
  // Status byte transmit
  // ----------------------------------------------------------------
  assign status_byte = {`EWPS_ST_UPPER,
                        bp_shown[1], bp_shown[0],
                        latch_reg,
                        busy};
  assign send_status = (state_reg == EWPS_RD_CMD ||
                        state_reg == EWPS_RD_BYTE) && is_mak;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_valid_reg <= 1'b0;
      tx_byte_reg <= 8'h00;
    end else begin
      tx_valid_reg <= send_status;
      if (send_status) begin
        tx_byte_reg <= status_byte;
      end
    end
  end

  // ----------------------------------------------------------------
  // Write start outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_start_reg <= 1'b0;
      wr_kind_reg <= EWPS_WK_PAGE;
      wr_addr_reg <= 8'h00;
      wr_data_reg <= 8'h00;
    end else begin
      wr_start_reg <= start_any;
      if (start_any) begin
        wr_kind_reg <= start_kind;
        wr_addr_reg <= go_page ? page_addr_i : 8'h00;
        wr_data_reg <= (start_kind == EWPS_WK_FILL) ?
                       `EWPS_FILL_DATA : `EWPS_CLEAR_DATA;
      end
    end
  end

  // ----------------------------------------------------------------
  // Power state
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      power_reg <= EWPS_PWR_SHUT;
    end else begin
      case (state_next)
        EWPS_SHUT: power_reg <= EWPS_PWR_SHUT;
        EWPS_IDLE: power_reg <= EWPS_PWR_IDLE;
        EWPS_STBY: power_reg <= EWPS_PWR_IDLE;
        default: power_reg <= EWPS_PWR_ACTIVE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign slave_ack_o = slave_ack_reg;
  assign cmd_reject_o = reject_reg;
  assign tx_valid_o = tx_valid_reg;
  assign tx_byte_o = tx_byte_reg;
  assign wr_start_o = wr_start_reg;
  assign wr_kind_o = wr_kind_reg;
  assign wr_addr_o = wr_addr_reg;
  assign wr_data_o = wr_data_reg;
  assign array_ready_o = !busy;
  assign busy_o = busy;
  assign latch_o = latch_reg;
  assign protect_o = bp;
  assign power_o = power_reg;

endmodule

//--- core/ewps_consts.svh
// How it works
// - No internal write without latch set.
// - Arm sets latch, disarm clears latch.
// - Arm or disarm needs nack, else idle.
// - Latch cleared at power-up and writes.
// - Status read accepted at any moment.
// - Upper four status bits read zero.
// - Busy flag shows internal write cycle.
// - Latch flag changed by arm/disarm and cleared at write start.
// - Protect bits kept nonvolatile, status-write only.
// - Read during status-write shows new bits.
// - Busy and latch flags update live.
// - Ack repeats status byte, nack ends.
// - Status-write data needs nack, else idle.
// - Protect pair selects none, quarter, half, all.
// - Clear-all writes zeros after closing nack.
// - Fill-all writes ones after closing nack.
// - Clear/fill ignored when any block protected.
// - Clear or fill needs nack, else idle.
// - Array and status writes ignored while busy.
// - Power-on shutdown; rising edge gives idle.
// - Rise, standby, falling edge make active.
// - Latch gates every write; protection gates array writes.
// - Codes 96h arm, 91h disarm, 05h read.
// - Codes 6Eh write, 6Dh clear, 67h fill.
`ifndef EWPS_CONSTS_SVH
`define EWPS_CONSTS_SVH

// ----------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------
`define EWPS_CMD_ARM 8'h96
`define EWPS_CMD_DISARM 8'h91
`define EWPS_CMD_STAT_RD 8'h05
`define EWPS_CMD_STAT_WR 8'h6E
`define EWPS_CMD_CLEAR 8'h6D
`define EWPS_CMD_FILL 8'h67

// ----------------------------------------------------------------
// Status byte layout and values
// ----------------------------------------------------------------
`define EWPS_ST_BUSY 0
`define EWPS_ST_LATCH 1
`define EWPS_ST_BP_LO 2
`define EWPS_ST_BP_HI 3
`define EWPS_ST_UPPER 4'h0
`define EWPS_BP_FACTORY 2'h1
`define EWPS_BP_NONE 2'h0
`define EWPS_BP_QUARTER 2'h1
`define EWPS_BP_HALF 2'h2
`define EWPS_BP_ALL 2'h3
`define EWPS_QUARTER_BASE 8'hC0
`define EWPS_HALF_BASE 8'h80
`define EWPS_CLEAR_DATA 8'h00
`define EWPS_FILL_DATA 8'hFF

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define EWPS_CLK_NS 20
`define EWPS_TWC_NS 5000000
`define EWPS_TWC_CYC ((`EWPS_TWC_NS + `EWPS_CLK_NS - 1) / `EWPS_CLK_NS)

`endif

//--- core/ewps_pkg.sv
package ewps_pkg;

  typedef enum logic [3:0] {
    EWPS_SHUT = 4'h0,
    EWPS_IDLE = 4'h1,
    EWPS_STBY = 4'h2,
    EWPS_HDR = 4'h3,
    EWPS_ONE_END = 4'h4,
    EWPS_RD_CMD = 4'h5,
    EWPS_RD_BYTE = 4'h6,
    EWPS_WS_CMD = 4'h7,
    EWPS_WS_DATA = 4'h8,
    EWPS_WS_END = 4'h9
  } ewps_state_e;

  typedef enum logic [1:0] {
    EWPS_WK_PAGE = 2'h0,
    EWPS_WK_CLEAR = 2'h1,
    EWPS_WK_FILL = 2'h2,
    EWPS_WK_STATUS = 2'h3
  } ewps_kind_e;

  typedef enum logic [1:0] {
    EWPS_PWR_SHUT = 2'h0,
    EWPS_PWR_IDLE = 2'h1,
    EWPS_PWR_ACTIVE = 2'h2
  } ewps_power_e;

endpackage

//--- core/ewps_nvcell.sv
`include "ewps_consts.svh"

module ewps_nvcell
  import ewps_pkg::*;
#(
  parameter int unsigned TWC_CYCLES = `EWPS_TWC_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic nv_init_i,
  input wire logic start_i,
  input wire ewps_kind_e kind_i,
  input wire logic [1:0] bp_new_i,
  output logic busy_o,
  output logic [1:0] bp_o,
  output logic [1:0] bp_shown_o
);

  logic [1:0] bp_store_reg;
  logic [1:0] bp_pend_reg;
  logic [31:0] count_reg;
  logic busy_reg;
  ewps_kind_e kind_reg;

  // ----------------------------------------------------------------
  // Write cycle timer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_reg <= 1'b0;
      count_reg <= 32'h0;
    end else if (busy_reg) begin
      if (count_reg == 32'h1) begin
        busy_reg <= 1'b0;
      end
      count_reg <= count_reg - 32'h1;
    end else if (start_i) begin
      busy_reg <= 1'b1;
      count_reg <= TWC_CYCLES;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      kind_reg <= EWPS_WK_PAGE;
      bp_pend_reg <= `EWPS_BP_NONE;
    end else if (start_i && !busy_reg) begin
      kind_reg <= kind_i;
      bp_pend_reg <= bp_new_i;
    end
  end

  // ----------------------------------------------------------------
  // Nonvolatile protect bits
  // ----------------------------------------------------------------
  // The cell keeps its content through rst_i unless factory init asks.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      if (nv_init_i) begin
        bp_store_reg <= `EWPS_BP_FACTORY;
      end
    end else if (busy_reg && count_reg == 32'h1 &&
                 kind_reg == EWPS_WK_STATUS) begin
      bp_store_reg <= bp_pend_reg;
    end
  end

  assign busy_o = busy_reg;
  assign bp_o = bp_store_reg;
  assign bp_shown_o = (busy_reg && kind_reg == EWPS_WK_STATUS) ?
                      bp_pend_reg : bp_store_reg;

endmodule

//--- tb/ewps_top_chk.sv
module ewps_top_chk #(
  parameter int unsigned TWC_CYCLES = 20
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic slave_ack_o,
  input wire logic cmd_reject_o,
  input wire logic tx_valid_o,
  input wire logic [7:0] tx_byte_o,
  input wire logic wr_start_o,
  input wire logic [1:0] wr_kind_o,
  input wire logic [7:0] wr_addr_o,
  input wire logic [7:0] wr_data_o,
  input wire logic array_ready_o,
  input wire logic busy_o,
  input wire logic latch_o,
  input wire logic [1:0] protect_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Busy length counter
  // ----------------------------------------------------------------
  logic [31:0] busy_cnt_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_cnt_reg <= 32'h0;
    end else begin
      busy_cnt_reg <= busy_o ? busy_cnt_reg + 32'h1 : 32'h0;
    end
  end

  default clocking dcb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  chk_upper_zero: assert property (
    tx_valid_o |-> tx_byte_o[7:4] == 4'h0) else $error("upper bits set");
  chk_start_latch: assert property (
    wr_start_o |-> $past(latch_o)) else $error("write without latch");
  chk_start_clears: assert property (
    wr_start_o |-> !latch_o && busy_o) else $error("latch kept on write");
  chk_start_idle: assert property (
    wr_start_o |-> !$past(busy_o)) else $error("write started while busy");
  chk_ready_busy: assert property (
    array_ready_o == !busy_o) else $error("ready does not track busy");
  chk_busy_len: assert property (
    $fell(busy_o) |-> $past(busy_cnt_reg) == TWC_CYCLES - 1)
    else $error("busy length wrong");
  chk_busy_max: assert property (
    busy_o |-> busy_cnt_reg < TWC_CYCLES) else $error("busy too long");
  chk_bulk_open: assert property (
    wr_start_o && (wr_kind_o == 2'h1 || wr_kind_o == 2'h2)
    |-> $past(protect_o) == 2'h0) else $error("bulk write when protected");
  chk_clear_zero: assert property (
    wr_start_o && wr_kind_o == 2'h1 |-> wr_data_o == 8'h00)
    else $error("clear data wrong");
  chk_fill_ones: assert property (
    wr_start_o && wr_kind_o == 2'h2 |-> wr_data_o == 8'hFF)
    else $error("fill data wrong");
  chk_page_open: assert property (
    wr_start_o && wr_kind_o == 2'h0 |-> $past(protect_o) == 2'h0
    || ($past(protect_o) == 2'h1 && wr_addr_o < 8'hC0)
    || ($past(protect_o) == 2'h2 && wr_addr_o < 8'h80))
    else $error("page write into protected block");
  chk_reject_mute: assert property (
    cmd_reject_o |-> !slave_ack_o && !wr_start_o && !tx_valid_o)
    else $error("reject with answer");
  chk_protect_hold: assert property (
    $changed(protect_o) |-> $past(busy_o) || $past(busy_o, 2))
    else $error("protect bits changed outside write");

  cov_status_tx: cover property (tx_valid_o);
  cov_clear: cover property (wr_start_o && wr_kind_o == 2'h1);
  cov_fill: cover property (wr_start_o && wr_kind_o == 2'h2);
  cov_reject: cover property (cmd_reject_o);
endmodule

bind ewps_top ewps_top_chk #(.TWC_CYCLES(TWC_CYCLES)) u_chk (.*);

//--- tb/ewps_master_model.sv
module ewps_master_model (
  input wire logic clk_i,
  output logic rise_o,
  output logic stby_o,
  output logic hdr_o,
  output logic cmd_v_o,
  output logic [7:0] cmd_o,
  output logic dat_v_o,
  output logic [7:0] dat_o,
  output logic ack_v_o,
  output logic mak_o,
  output logic page_v_o,
  output logic [7:0] addr_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    {rise_o, stby_o, hdr_o, cmd_v_o, dat_v_o, ack_v_o, page_v_o} = 7'h00;
    {cmd_o, dat_o, addr_o, mak_o} = 25'h0;
  end

  // ----------------------------------------------------------------
  // Each call drives at most one line event for one clock cycle.
  // ----------------------------------------------------------------
  task automatic send(input logic [2:0] k, input logic [7:0] b,
                      input logic m);
    rise_o = (k == 3'h0);
    stby_o = (k == 3'h1);
    hdr_o = (k == 3'h2);
    cmd_v_o = (k == 3'h3);
    cmd_o = (k == 3'h3) ? b : ~cmd_o;
    dat_v_o = (k == 3'h4);
    dat_o = (k == 3'h4) ? b : ~dat_o;
    ack_v_o = (k == 3'h5);
    mak_o = (k == 3'h5) ? m : ~mak_o;
    page_v_o = (k == 3'h6);
    addr_o = (k == 3'h6) ? b : ~addr_o;
    @(negedge clk_i);
  endtask
endmodule

//--- tb/eeprom_write_protect_status_tb_top.sv
module eeprom_write_protect_status_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_i, rst_i, nv_init_i;
  logic line_rise_i, standby_i, header_fall_i, cmd_valid_i, data_valid_i;
  logic ack_valid_i, ack_mak_i, page_write_i;
  logic [7:0] cmd_byte_i, data_byte_i, page_addr_i;
  logic slave_ack_o, cmd_reject_o, tx_valid_o, wr_start_o, array_ready_o;
  logic busy_o, latch_o;
  logic [7:0] tx_byte_o, wr_addr_o, wr_data_o;
  logic [1:0] wr_kind_o, protect_o, power_o;
  int fail_count = 0;
  int num_checks = 0;

  ewps_top #(.TWC_CYCLES(24)) dut (.*);

  ewps_master_model u_mst (
    .clk_i(clk_i), .rise_o(line_rise_i), .stby_o(standby_i),
    .hdr_o(header_fall_i), .cmd_v_o(cmd_valid_i), .cmd_o(cmd_byte_i),
    .dat_v_o(data_valid_i), .dat_o(data_byte_i), .ack_v_o(ack_valid_i),
    .mak_o(ack_mak_i), .page_v_o(page_write_i), .addr_o(page_addr_i)
  );

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic chk1(input logic seen, input logic exp);
    check({7'h0, seen}, {7'h0, exp});
  endtask

  task automatic op(input logic [7:0] c, input logic m);
    // The first standby pulse leaves an unfinished status read, the second enters standby.
    u_mst.send(3'h1, 8'h00, 1'b0);
    u_mst.send(3'h1, 8'h00, 1'b0);
    u_mst.send(3'h2, 8'h00, 1'b0);
    u_mst.send(3'h3, c, 1'b0);
    u_mst.send(3'h5, 8'h00, m);
  endtask

  task automatic wsr(input logic [7:0] d, input logic m);
    op(8'h6E, 1'b1);
    chk1(slave_ack_o, 1'b1);
    u_mst.send(3'h4, d, 1'b0);
    u_mst.send(3'h5, 8'h00, m);
  endtask

  task automatic wait_idle();
    int n = 0;
    u_mst.send(3'h7, 8'h00, 1'b0);
    while (busy_o !== 1'b0 && n < 100) begin
      u_mst.send(3'h7, 8'h00, 1'b0);
      n++;
    end
    if (n >= 100) begin
      fail_count++;
      $display("mismatch at %0t: busy never cleared", $time);
      report_and_stop();
    end
  endtask

  task automatic do_reset(input logic nv);
    rst_i = 1'b1;
    nv_init_i = nv;
    repeat (16) @(negedge clk_i);
    rst_i = 1'b0;
    nv_init_i = 1'b0;
    u_mst.send(3'h7, 8'h00, 1'b0);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_i = 1'b1;
    nv_init_i = 1'b1;
    @(negedge clk_i);
    do_reset(1'b1);
    check({6'h0, protect_o}, 8'h01);
    chk1(latch_o, 1'b0);
    check({6'h0, power_o}, 8'h00);
    u_mst.send(3'h1, 8'h00, 1'b0);
    check({6'h0, power_o}, 8'h00);
    u_mst.send(3'h0, 8'h00, 1'b0);
    check({6'h0, power_o}, 8'h01);
    u_mst.send(3'h1, 8'h00, 1'b0);
    u_mst.send(3'h2, 8'h00, 1'b0);
    check({6'h0, power_o}, 8'h02);
    u_mst.send(3'h3, 8'h05, 1'b0);
    u_mst.send(3'h5, 8'h00, 1'b1);
    check(tx_byte_o, 8'h04);
    u_mst.send(3'h5, 8'h00, 1'b1);
    chk1(tx_valid_o, 1'b1);
    u_mst.send(3'h5, 8'h00, 1'b0);
    chk1(tx_valid_o, 1'b0);
    op(8'h6D, 1'b0);
    chk1(wr_start_o, 1'b0);
    op(8'h96, 1'b1);
    check({6'h0, cmd_reject_o, latch_o}, 8'h02);
    op(8'h96, 1'b0);
    check({6'h0, slave_ack_o, latch_o}, 8'h03);
    op(8'h6D, 1'b0);
    check({6'h0, wr_start_o, latch_o}, 8'h01);
    op(8'h67, 1'b0);
    chk1(wr_start_o, 1'b0);
    op(8'h91, 1'b0);
    chk1(latch_o, 1'b0);
    wsr(8'hF3, 1'b0);
    check({5'h0, wr_start_o, protect_o}, 8'h01);
    op(8'h96, 1'b0);
    wsr(8'hF3, 1'b1);
    check({6'h0, cmd_reject_o, latch_o}, 8'h03);
    wsr(8'hF3, 1'b0);
    check({3'h0, wr_kind_o, wr_start_o, latch_o, busy_o}, 8'h1D);
    op(8'h05, 1'b1);
    check(tx_byte_o, 8'h01);
    op(8'h96, 1'b0);
    op(8'h05, 1'b1);
    check(tx_byte_o, 8'h03);
    op(8'h6D, 1'b0);
    check({5'h0, array_ready_o, wr_start_o, busy_o}, 8'h01);
    wait_idle();
    check({5'h0, latch_o, protect_o}, 8'h04);
    op(8'h6D, 1'b0);
    check({4'h0, wr_kind_o, wr_start_o, latch_o}, 8'h06);
    check(wr_data_o, 8'h00);
    wait_idle();
    op(8'h96, 1'b0);
    op(8'h67, 1'b0);
    check({5'h0, wr_kind_o, wr_start_o}, 8'h05);
    check(wr_data_o, 8'hFF);
    wait_idle();
    op(8'h96, 1'b0);
    op(8'h6D, 1'b1);
    check({6'h0, cmd_reject_o, wr_start_o}, 8'h02);
    op(8'h96, 1'b0);
    wsr(8'h08, 1'b0);
    wait_idle();
    check({6'h0, protect_o}, 8'h02);
    op(8'h96, 1'b0);
    u_mst.send(3'h6, 8'h80, 1'b0);
    chk1(wr_start_o, 1'b0);
    u_mst.send(3'h6, 8'h40, 1'b0);
    check({6'h0, wr_start_o, latch_o}, 8'h02);
    check(wr_addr_o, 8'h40);
    wait_idle();
    do_reset(1'b0);
    check({5'h0, latch_o, protect_o}, 8'h02);
    report_and_stop();
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    $display("mismatch at %0t: run did not finish", $time);
    report_and_stop();
  end
endmodule
